// *** rtl/boot_clock_reset_select.sv ***
// strap decode, soft reset sequencing and watchdog hookup
//
// Behaviour
// - boot 000 eMMC with usb fallback, 100 eMMC only
// - 001 card slave pass-through with fallback, 010 without
// - 011 relayed secure boot, 1F1 adds usb fallback
// - 101 sync muxed port, 110 legacy, 111 usb
// - 00F async sram, 01F async muxed port
// - 10F i2c with usb fallback, 11F i2c only
// - boot source from straps only; others reserved
// - hard reset tristates every pin while held
// - host init control bits start soft resets
// - cpu reset clears pc, keeps loaded firmware
// - device reset equals hard reset, firmware reload
// - frequency straps pick crystal or external clock
// - pll ratio keeps core rate frequency independent
// - watchdog interrupts, wakes standby, resets cpu
// - watchdog counts 32 kHz, optionally external pin
// - periodic standby wake; firmware may disable watchdog
// - eMMC boot uses sdr clock up to 52 MHz
// - wake from standby restarts cpu at reset pc
`timescale 1ns/1ns
`default_nettype none
module boot_clock_reset_select
  import boot_cfg_pkg::*;
#(
  parameter int WD_W = 16
) (
  input  wire logic            mclk_i,
  input  wire logic            rst_n_i,
  input  wire logic            ce_i,
  input  wire logic [2:0]      boot_source_strap_i,
  input  wire logic [2:0]      boot_strap_float_i,
  input  wire logic [2:0]      ref_freq_strap_i,
  input  wire logic            slow_watchdog_clock_in_i,
  input  wire logic            slow_clk_ext_sel_i,
  input  wire logic            cpu_reset_req_i,
  input  wire logic            device_reset_req_i,
  input  wire logic            fw_loaded_i,
  input  wire logic            standby_i,
  input  wire logic            wdog_enable_i,
  input  wire logic            wdog_wake_en_i,
  input  wire logic            wdog_reset_en_i,
  input  wire logic            wdog_kick_i,
  input  wire logic [WD_W-1:0] wdog_period_i,
  input  wire logic            wdog_irq_ack_i,
  output var  boot_src_t       boot_src_o,
  output logic                 usb_fallback_o,
  output logic                 secure_boot_o,
  output logic                 boot_reserved_o,
  output logic                 strap_valid_o,
  output var  ref_sel_t        ref_sel_o,
  output logic                 crystal_sel_o,
  output logic                 freq_reserved_o,
  output logic [7:0]           pll_mult_o,
  output logic [7:0]           pll_div_o,
  output logic [3:0]           emmc_clk_div_o,
  output logic                 emmc_ddr_o,
  output logic                 pins_tristate_o,
  output logic                 sys_reset_n_o,
  output logic                 cpu_reset_n_o,
  output logic                 fw_reload_o,
  output logic                 wdog_irq_o,
  output logic                 wake_o
);
  typedef enum logic [1:0] {ST_SETTLE, ST_RUN, ST_DEVRST} rst_state_t;

  localparam int PW = 10; // straps, float flags, frequency, slow clock

  // decode of the boot straps, F meaning a floating strap
  function automatic boot_cfg_t decode_boot(input logic [2:0] v,
                                            input logic [2:0] f);
    boot_cfg_t c;
    c = '{src: BOOT_NONE, usb_fb: 1'b0, secure: 1'b0, reserved: 1'b1};
    if (f == 3'h0) begin
      c.reserved = 1'b0;
      case (v)
        3'h0: c = '{BOOT_EMMC, 1'b1, 1'b0, 1'b0};
        3'h4: c = '{BOOT_EMMC, 1'b0, 1'b0, 1'b0};
        3'h1: c = '{BOOT_CARD_PASS, 1'b1, 1'b0, 1'b0};
        3'h2: c = '{BOOT_CARD_PASS, 1'b0, 1'b0, 1'b0};
        3'h3: c = '{BOOT_CARD_RELAY, 1'b0, 1'b1, 1'b0};
        3'h5: c = '{BOOT_MUX_SYNC, 1'b0, 1'b0, 1'b0};
        3'h6: c = '{BOOT_CARD_LEGACY, 1'b0, 1'b0, 1'b0};
        default: c = '{BOOT_USB, 1'b0, 1'b0, 1'b0};
      endcase
    end else if (f == 3'h1) begin
      case (v[2:1])
        2'h0: c = '{BOOT_SRAM_ASYNC, 1'b0, 1'b0, 1'b0};
        2'h1: c = '{BOOT_MUX_ASYNC, 1'b0, 1'b0, 1'b0};
        2'h2: c = '{BOOT_I2C, 1'b1, 1'b0, 1'b0};
        default: c = '{BOOT_I2C, 1'b0, 1'b0, 1'b0};
      endcase
    end else if (f == 3'h2 && v[2] && v[0]) begin
      c = '{BOOT_CARD_RELAY, 1'b1, 1'b1, 1'b0};
    end
    return c; // any other pattern stays reserved
  endfunction : decode_boot

  // frequency straps: top bit low means crystal, only 000 is legal
  function automatic ref_sel_t decode_ref(input logic [2:0] v);
    ref_sel_t r;
    if (!v[2]) begin
      r = (v[1:0] == 2'h0) ? REF_XTAL_19M2 : REF_BAD;
    end else if (v[1:0] == 2'h0) begin
      r = REF_CLK_19M2;
    end else if (v[1:0] == 2'h1) begin
      r = REF_CLK_26M;
    end else if (v[1:0] == 2'h2) begin
      r = REF_CLK_38M4;
    end else begin
      r = REF_CLK_52M;
    end
    return r;
  endfunction : decode_ref

  // pin synchroniser and filtered copies
  logic [PW-1:0]    s1_r, s2_r, s3_r, filt_r, filt_nxt;
  logic             slow_prev_r;
  logic [CNT_W-1:0] div_r, div_nxt;
  // sequencing state
  rst_state_t       state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt, cpu_cnt_r, cpu_cnt_nxt;
  boot_cfg_t        boot_r, boot_nxt;
  ref_sel_t         ref_r, ref_nxt;
  logic             valid_r, valid_nxt, tri_r, tri_nxt;
  logic             sys_n_r, sys_n_nxt, cpu_n_r, cpu_n_nxt;
  logic             fwrl_r, fwrl_nxt, irq_r, irq_nxt, wake_r, wake_nxt;
  logic [7:0]       mult_nxt, div8_nxt, mult_r, pdiv_r;
  logic             xtal_r, xtal_nxt, fres_r, fres_nxt;
  logic             tick;
  logic             wake_evt;

  wdog_if #(.WD_W(WD_W)) wdi ();

  wdog_core #(.WD_W(WD_W)) u_wdog (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .w       (wdi.wd)
  );

  // slow tick: external pin edge or internal divider
  assign tick = slow_clk_ext_sel_i ? (filt_r[0] && !slow_prev_r)
                                   : (div_r == CNT_W'(SLOW_TICK_CYC - 1));
  assign wdi.slow_tick = tick;
  assign wdi.srst      = (state_r != ST_RUN);
  assign wdi.enable    = wdog_enable_i;
  assign wdi.reset_en  = wdog_reset_en_i;
  assign wdi.kick      = wdog_kick_i;
  assign wdi.period    = wdog_period_i;
  // standby wake on watchdog expiry
  assign wake_evt = wdi.expire && standby_i && wdog_wake_en_i;

  // next values for the whole block
  always_comb begin
    filt_nxt    = filt_r;
    if (s2_r == s3_r) filt_nxt = s3_r; // two agreeing stages
    div_nxt     = tick ? '0 : div_r + 1'b1;
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    cpu_cnt_nxt = cpu_cnt_r;
    boot_nxt    = boot_r;
    ref_nxt     = ref_r;
    valid_nxt   = valid_r;
    sys_n_nxt   = sys_n_r;
    cpu_n_nxt   = cpu_n_r;
    fwrl_nxt    = fwrl_r && !fw_loaded_i;
    irq_nxt     = (irq_r && !wdog_irq_ack_i) || wdi.expire;
    wake_nxt    = 1'b0;
    case (state_r)
      ST_SETTLE: begin
        // let straps ripple through the synchroniser before sampling
        if (cnt_r == CNT_W'(STRAP_SETTLE_CYC - 1)) begin
          boot_nxt  = decode_boot(filt_r[9:7], filt_r[6:4]);
          ref_nxt   = decode_ref(filt_r[3:1]);
          valid_nxt = 1'b1;
          sys_n_nxt = 1'b1;
          cpu_n_nxt = 1'b1;
          state_nxt = ST_RUN;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      ST_RUN: begin
        if (device_reset_req_i) begin
          state_nxt = ST_DEVRST;
          cnt_nxt   = '0;
          valid_nxt = 1'b0;
          sys_n_nxt = 1'b0;
          cpu_n_nxt = 1'b0;
          fwrl_nxt  = 1'b1;
          cpu_cnt_nxt = '0;           // no leftover cpu hold
        end else if (cpu_reset_req_i || wdi.bite || wake_evt) begin
          // pc reset only, firmware flag untouched
          cpu_n_nxt   = 1'b0;
          cpu_cnt_nxt = CNT_W'(SOFT_RST_CYC - 1);
          wake_nxt    = wake_evt;
        end else if (cpu_cnt_r != '0) begin
          cpu_cnt_nxt = cpu_cnt_r - 1'b1;
        end else begin
          cpu_n_nxt = 1'b1;
        end
      end
      default: begin
        // hold like a hard reset, then resample the straps
        if (cnt_r == CNT_W'(SOFT_RST_CYC - 1)) begin
          state_nxt = ST_SETTLE;
          cnt_nxt   = '0;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
    endcase
    tri_nxt = (state_nxt != ST_RUN);
    if (state_nxt != ST_RUN) irq_nxt = 1'b0; // like hard reset
    xtal_nxt = (ref_nxt == REF_XTAL_19M2);
    fres_nxt = (ref_nxt == REF_BAD);
    // pll ratio from the sampled reference
    case (ref_nxt)
      REF_CLK_26M:  {mult_nxt, div8_nxt} = {PLL_MULT_26M, PLL_DIV_26M};
      REF_CLK_38M4: {mult_nxt, div8_nxt} = {PLL_MULT_38M4, PLL_DIV_38M4};
      REF_CLK_52M:  {mult_nxt, div8_nxt} = {PLL_MULT_52M, PLL_DIV_52M};
      default:      {mult_nxt, div8_nxt} = {PLL_MULT_19M2, PLL_DIV_19M2};
    endcase
  end

  // registers; hard reset forces pins to high impedance
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_r        <= '0;
      s2_r        <= '0;
      s3_r        <= '0;
      filt_r      <= '0;
      slow_prev_r <= 1'b0;
      div_r       <= '0;
      state_r     <= ST_SETTLE;
      cnt_r       <= '0;
      cpu_cnt_r   <= '0;
      boot_r      <= '{BOOT_NONE, 1'b0, 1'b0, 1'b0};
      ref_r       <= REF_XTAL_19M2;
      valid_r     <= 1'b0;
      tri_r       <= 1'b1;
      sys_n_r     <= 1'b0;
      cpu_n_r     <= 1'b0;
      fwrl_r      <= 1'b1;
      irq_r       <= 1'b0;
      wake_r      <= 1'b0;
      mult_r      <= PLL_MULT_19M2;
      pdiv_r      <= PLL_DIV_19M2;
      xtal_r      <= 1'b1;
      fres_r      <= 1'b0;
    end else if (ce_i) begin
      s1_r        <= {boot_source_strap_i, boot_strap_float_i,
                      ref_freq_strap_i, slow_watchdog_clock_in_i};
      s2_r        <= s1_r;
      s3_r        <= s2_r;
      filt_r      <= filt_nxt;
      slow_prev_r <= filt_r[0];
      div_r       <= div_nxt;
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      cpu_cnt_r   <= cpu_cnt_nxt;
      boot_r      <= boot_nxt;
      ref_r       <= ref_nxt;
      valid_r     <= valid_nxt;
      tri_r       <= tri_nxt;
      sys_n_r     <= sys_n_nxt;
      cpu_n_r     <= cpu_n_nxt;
      fwrl_r      <= fwrl_nxt;
      irq_r       <= irq_nxt;
      wake_r      <= wake_nxt;
      mult_r      <= mult_nxt;
      pdiv_r      <= div8_nxt;
      xtal_r      <= xtal_nxt;
      fres_r      <= fres_nxt;
    end
  end

  assign boot_src_o      = boot_r.src;
  assign usb_fallback_o  = boot_r.usb_fb;
  assign secure_boot_o   = boot_r.secure;
  assign boot_reserved_o = boot_r.reserved;
  assign strap_valid_o   = valid_r;
  assign ref_sel_o       = ref_r;
  assign crystal_sel_o   = xtal_r;
  assign freq_reserved_o = fres_r;
  assign pll_mult_o      = mult_r;
  assign pll_div_o       = pdiv_r;
  assign emmc_clk_div_o  = EMMC_SDR_DIV; // fixed sdr rate
  assign emmc_ddr_o      = 1'b0;
  assign pins_tristate_o = tri_r;
  assign sys_reset_n_o   = sys_n_r;
  assign cpu_reset_n_o   = cpu_n_r;
  assign fw_reload_o     = fwrl_r;
  assign wdog_irq_o      = irq_r;
  assign wake_o          = wake_r;

  sequence s_dev_req;
    ce_i && state_r == ST_RUN && device_reset_req_i;
  endsequence
  sequence s_dev_hold;
    (!sys_reset_n_o && pins_tristate_o && fw_reload_o)[*8];
  endsequence

  a_dev_reset_hold: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i) s_dev_req |=> s_dev_hold)
    else $error("device reset did not hold like hard reset");

  a_pins_tristated: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    state_r != ST_RUN |-> pins_tristate_o && !strap_valid_o)
    else $error("pins driven outside run state");

  a_straps_held: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i) strap_valid_o && $past(strap_valid_o)
      |-> $stable(boot_src_o) && $stable(ref_sel_o))
    else $error("sampled straps changed while valid");

  a_cpu_reset_only: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    ce_i && state_r == ST_RUN && cpu_reset_req_i && !device_reset_req_i
      |=> !cpu_reset_n_o && sys_reset_n_o && strap_valid_o)
    else $error("cpu reset touched more than the cpu");

  a_wake_cpu_reset: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i) wake_o |-> !cpu_reset_n_o && wdog_irq_o)
    else $error("standby wake without cpu restart");

  a_pll_ratio: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i) strap_valid_o && ref_sel_o == REF_CLK_52M
      |-> pll_mult_o == PLL_MULT_52M && pll_div_o == PLL_DIV_52M)
    else $error("pll ratio does not match reference");

endmodule : boot_clock_reset_select
`default_nettype wire

// *** rtl/boot_cfg_pkg.sv ***
// shared constants and types for boot, clock and reset selection
package boot_cfg_pkg;

  // clock and time base
  localparam int MCLK_HZ          = 100_000_000;
  localparam int MCLK_PERIOD_NS   = 10;
  localparam int SLOW_CLK_HZ      = 32768;
  localparam int SLOW_TICK_CYC    = MCLK_HZ / SLOW_CLK_HZ;
  localparam int SOFT_RST_NS      = 1000;
  localparam int SOFT_RST_CYC     =
    (SOFT_RST_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int STRAP_SETTLE_CYC = 8;
  localparam int CNT_W            = 12;

  // pll ratios: every reference lands on one common core rate
  localparam logic [7:0] PLL_MULT_19M2 = 8'h41;
  localparam logic [7:0] PLL_DIV_19M2  = 8'h03;
  localparam logic [7:0] PLL_MULT_26M  = 8'h10;
  localparam logic [7:0] PLL_DIV_26M   = 8'h01;
  localparam logic [7:0] PLL_MULT_38M4 = 8'h41;
  localparam logic [7:0] PLL_DIV_38M4  = 8'h06;
  localparam logic [7:0] PLL_MULT_52M  = 8'h08;
  localparam logic [7:0] PLL_DIV_52M   = 8'h01;
  // storage port boot clock divider: core rate / 8 = 52 MHz sdr
  localparam logic [3:0] EMMC_SDR_DIV  = 4'h8;

  // reset values
  localparam logic [15:0] WD_PERIOD_RST = 16'h8000;

  typedef enum logic [3:0] {
    BOOT_EMMC, BOOT_CARD_PASS, BOOT_CARD_RELAY, BOOT_MUX_SYNC,
    BOOT_CARD_LEGACY, BOOT_USB, BOOT_SRAM_ASYNC, BOOT_MUX_ASYNC,
    BOOT_I2C, BOOT_NONE
  } boot_src_t;

  typedef enum logic [2:0] {
    REF_XTAL_19M2, REF_CLK_19M2, REF_CLK_26M, REF_CLK_38M4,
    REF_CLK_52M, REF_BAD
  } ref_sel_t;

  typedef struct packed {
    boot_src_t src;
    logic      usb_fb;
    logic      secure;
    logic      reserved;
  } boot_cfg_t;

endpackage : boot_cfg_pkg

// *** rtl/wdog_if.sv ***
// control and event bundle between reset control and watchdog
`timescale 1ns/1ns
`default_nettype none
interface wdog_if #(parameter int WD_W = 16);
  logic            slow_tick;
  logic            srst;
  logic            enable;
  logic            reset_en;
  logic            kick;
  logic [WD_W-1:0] period;
  logic            expire;
  logic            bite;

  modport ctl (output slow_tick, srst, enable, reset_en, kick, period,
               input  expire, bite);
  modport wd  (input  slow_tick, srst, enable, reset_en, kick, period,
               output expire, bite);
endinterface : wdog_if
`default_nettype wire

// *** rtl/wdog_core.sv ***
// watchdog counter running on slow clock ticks
`timescale 1ns/1ns
`default_nettype none
module wdog_core #(
  parameter int WD_W = 16
) (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  wdog_if.wd        w
);
  logic [WD_W-1:0] cnt_r,    cnt_nxt;
  logic            armed_r,  armed_nxt;
  logic            expire_r, expire_nxt;
  logic            bite_r,   bite_nxt;

  assign w.expire = expire_r;
  assign w.bite   = bite_r;

  // count down on each slow tick; a second unserviced expiry bites
  always_comb begin
    cnt_nxt    = cnt_r;
    armed_nxt  = armed_r;
    expire_nxt = 1'b0;
    bite_nxt   = 1'b0;
    if (w.srst || !w.enable) begin
      cnt_nxt   = w.period;
      armed_nxt = 1'b0;
    end else if (w.kick) begin
      cnt_nxt   = w.period;
      armed_nxt = 1'b0;
    end else if (w.slow_tick) begin
      if (cnt_r == '0) begin
        cnt_nxt    = w.period;
        expire_nxt = 1'b1;
        armed_nxt  = 1'b1;
        bite_nxt   = armed_r && w.reset_en;
      end else begin
        cnt_nxt = cnt_r - 1'b1;
      end
    end
  end

  // register stage, frozen while the clock enable is low
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r    <= '0;
      armed_r  <= 1'b0;
      expire_r <= 1'b0;
      bite_r   <= 1'b0;
    end else if (ce_i) begin
      cnt_r    <= cnt_nxt;
      armed_r  <= armed_nxt;
      expire_r <= expire_nxt;
      bite_r   <= bite_nxt;
    end
  end

  a_wd_off_quiet: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i) ce_i && !w.enable |=> !w.expire)
    else $error("watchdog expired while disabled");

  a_wd_bite_armed: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i) w.bite |-> w.expire && $past(armed_r))
    else $error("watchdog bite without earlier expiry");

  a_wd_kick_reload: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    ce_i && w.kick |=> !w.expire && cnt_r == $past(w.period))
    else $error("kick did not reload the watchdog");

endmodule : wdog_core
`default_nettype wire

// *** tb/host_side_model.sv ***
// host side model: slow watchdog clock source and firmware loader
`timescale 1ns/1ns
`default_nettype none
module host_side_model #(
  parameter int HALF_CYC = 10
) (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic fw_reload_i,
  input  wire logic strap_valid_i,
  output logic      slow_clk_o = 1'b0,
  output logic      fw_loaded_o = 1'b0
);
  int unsigned div_cnt  = 0;
  int unsigned load_cnt = 0;

  // free running slow clock, sped up so watchdog runs stay short
  always @(posedge mclk_i) begin
    div_cnt <= (div_cnt + 1) % HALF_CYC;
    if (div_cnt == 0) slow_clk_o <= ~slow_clk_o;
  end

  // host reloads firmware only once the device runs again
  always @(posedge mclk_i) begin
    fw_loaded_o <= 1'b0;
    if (!rst_n_i || !strap_valid_i || !fw_reload_i) load_cnt <= 0;
    else if (load_cnt < 5) load_cnt <= load_cnt + 1;
    else fw_loaded_o <= 1'b1;
  end
endmodule : host_side_model
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for strap decode, resets and watchdog
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top
  import boot_cfg_pkg::*;
;
  logic        mclk_i = 1'b0, rst_n_i = 1'b0;
  logic [2:0]  boot_strap = 3'h0, float_strap = 3'h0, freq_strap = 3'h0;
  logic        ext_sel = 1'b1, cpu_req = 1'b0, dev_req = 1'b0;
  logic        standby = 1'b0, wd_en = 1'b0, wake_en = 1'b0;
  logic        rst_en = 1'b0, kick = 1'b0, ack = 1'b0;
  logic [15:0] period = 16'h0003;
  logic        slow_clk, fw_loaded, usb_fb, secure, boot_res, valid;
  logic        xtal, freq_res, ddr, pins_z, sys_rst_n, cpu_rst_n;
  logic        reload, irq, wake;
  logic [7:0]  mult, div;
  logic [3:0]  emmc_div;
  boot_src_t   boot_src;
  ref_sel_t    ref_sel;
  int          n_mismatch = 0, compares = 0, i, k;
  logic [31:0] rnd = 32'h09E2BAE5;
  logic [8:0]  exp_q [$];
  logic [5:0]  codes [16] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05,
    6'h06, 6'h07, 6'h08, 6'h0A, 6'h0C, 6'h0E, 6'h15, 6'h17, 6'h20, 6'h10};

  boot_clock_reset_select i_boot_clock_reset_select (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
    .boot_source_strap_i(boot_strap), .boot_strap_float_i(float_strap),
    .ref_freq_strap_i(freq_strap), .slow_watchdog_clock_in_i(slow_clk),
    .slow_clk_ext_sel_i(ext_sel), .cpu_reset_req_i(cpu_req),
    .device_reset_req_i(dev_req), .fw_loaded_i(fw_loaded),
    .standby_i(standby), .wdog_enable_i(wd_en), .wdog_wake_en_i(wake_en),
    .wdog_reset_en_i(rst_en), .wdog_kick_i(kick), .wdog_period_i(period),
    .wdog_irq_ack_i(ack), .boot_src_o(boot_src), .usb_fallback_o(usb_fb),
    .secure_boot_o(secure), .boot_reserved_o(boot_res),
    .strap_valid_o(valid), .ref_sel_o(ref_sel), .crystal_sel_o(xtal),
    .freq_reserved_o(freq_res), .pll_mult_o(mult), .pll_div_o(div),
    .emmc_clk_div_o(emmc_div), .emmc_ddr_o(ddr), .pins_tristate_o(pins_z),
    .sys_reset_n_o(sys_rst_n), .cpu_reset_n_o(cpu_rst_n),
    .fw_reload_o(reload), .wdog_irq_o(irq), .wake_o(wake));

  host_side_model i_host_side_model (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .fw_reload_i(reload),
    .strap_valid_i(valid), .slow_clk_o(slow_clk), .fw_loaded_o(fw_loaded));

  // free running system clock
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  // reference decode of boot straps and floating flags
  function automatic boot_cfg_t exp_boot(logic [2:0] s, logic [2:0] f);
    boot_src_t t0 [8] = '{BOOT_EMMC, BOOT_CARD_PASS, BOOT_CARD_PASS,
      BOOT_CARD_RELAY, BOOT_EMMC, BOOT_MUX_SYNC, BOOT_CARD_LEGACY, BOOT_USB};
    boot_src_t t1 [4] = '{BOOT_SRAM_ASYNC, BOOT_MUX_ASYNC, BOOT_I2C,
      BOOT_I2C};
    boot_cfg_t e;
    e = '{BOOT_NONE, 1'b0, 1'b0, 1'b1};
    if (f == 3'h0) e = '{t0[s], s < 3'h2, s == 3'h3, 1'b0};
    else if (f == 3'h1) e = '{t1[s[2:1]], s[2:1] == 2'h2, 1'b0, 1'b0};
    else if (f == 3'h2 && s[2] && s[0])
      e = '{BOOT_CARD_RELAY, 1'b1, 1'b1, 1'b0};
    return e;
  endfunction : exp_boot

  function automatic ref_sel_t exp_ref(logic [2:0] q);
    ref_sel_t t [4] = '{REF_CLK_19M2, REF_CLK_26M, REF_CLK_38M4, REF_CLK_52M};
    if (q[2]) return t[q[1:0]];
    return (q == 3'h0) ? REF_XTAL_19M2 : REF_BAD;
  endfunction : exp_ref

  function automatic logic [15:0] exp_pll(ref_sel_t r);
    case (r)
      REF_CLK_26M:  return {PLL_MULT_26M, PLL_DIV_26M};
      REF_CLK_38M4: return {PLL_MULT_38M4, PLL_DIV_38M4};
      REF_CLK_52M:  return {PLL_MULT_52M, PLL_DIV_52M};
      default:      return {PLL_MULT_19M2, PLL_DIV_19M2};
    endcase
  endfunction : exp_pll

  task automatic step(int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : step

  task automatic done(string nm);
    $display("test %s done", nm);
  endtask : done

  task automatic drive_straps(logic [2:0] s, logic [2:0] f, logic [2:0] q);
    @(posedge mclk_i);
    boot_strap <= s;
    float_strap <= f;
    freq_strap <= q;
    exp_q.push_back({f, s, q});
  endtask : drive_straps

  // wait for run, wiggle straps, then compare against latched values
  task automatic run_start();
    logic [8:0] e;
    boot_cfg_t  c;
    ref_sel_t   r;
    for (k = 0; k < 40 && valid !== 1'b1; k++) step(1);
    `CHK(valid, 1'b1)
    rnd = lfsr(rnd);
    @(posedge mclk_i);
    {boot_strap, float_strap, freq_strap} <= rnd[8:0];
    step(10);
    e = exp_q.pop_front();
    c = exp_boot(e[5:3], e[8:6]);
    r = exp_ref(e[2:0]);
    `CHK(boot_src, c.src)
    `CHK({usb_fb, secure, boot_res}, c[2:0])
    `CHK(ref_sel, r)
    `CHK({xtal, freq_res}, {~|e[2:0], ~e[2] & |e[1:0]})
    `CHK({mult, div}, exp_pll(r))
    `CHK({emmc_div, ddr}, {EMMC_SDR_DIV, 1'b0})
    `CHK({pins_z, sys_rst_n, cpu_rst_n}, 3'b011)
    `CHK(reload, 1'b0)
  endtask : run_start

  task automatic hard_reset(logic [2:0] s, logic [2:0] f, logic [2:0] q);
    drive_straps(s, f, q);
    rst_n_i <= 1'b0;
    step(1);
    `CHK({pins_z, sys_rst_n, cpu_rst_n, valid, reload}, 5'h11)
    `CHK({boot_src, irq}, {BOOT_NONE, 1'b0})
    step(10);
    `CHK(pins_z, 1'b1)
    @(posedge mclk_i);
    rst_n_i <= 1'b1;
    run_start();
  endtask : hard_reset

  // device reset with a cpu request on the same edge
  task automatic dev_reset(logic [2:0] s, logic [2:0] f, logic [2:0] q);
    drive_straps(s, f, q);
    @(posedge mclk_i);
    {dev_req, cpu_req} <= 2'b11;
    @(posedge mclk_i);
    {dev_req, cpu_req} <= 2'b00;
    step(1);
    `CHK({sys_rst_n, pins_z, valid, reload}, 4'h5)
    step(95);
    `CHK({sys_rst_n, valid}, 2'b00)
    run_start();
  endtask : dev_reset

  task automatic cpu_pulse();
    @(posedge mclk_i);
    cpu_req <= 1'b1;
    @(posedge mclk_i);
    cpu_req <= 1'b0;
  endtask : cpu_pulse

  task automatic irq_ack();
    @(posedge mclk_i);
    ack <= 1'b1;
    @(posedge mclk_i);
    ack <= 1'b0;
  endtask : irq_ack

  task automatic wrap_up();
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  // hang guard, well past the expected run length
  initial begin
    #400000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    hard_reset(3'h0, 3'h0, 3'h0);
    done("hard reset");
    for (i = 0; i < 18; i++) begin
      rnd = lfsr(rnd);
      if (i < 16) dev_reset(codes[i][2:0], codes[i][5:3], i[2:0]);
      else dev_reset(rnd[2:0], rnd[5:3], rnd[8:6]);
    end
    done("strap decode");
    cpu_pulse();
    step(1);
    `CHK({cpu_rst_n, sys_rst_n, valid, reload}, 4'h6)
    step(48);
    cpu_pulse();
    step(95);
    `CHK(cpu_rst_n, 1'b0)
    for (k = 0; k < 20 && cpu_rst_n !== 1'b1; k++) step(1);
    `CHK({cpu_rst_n, reload}, 2'b10)
    done("cpu reset");
    @(posedge mclk_i);
    {standby, wake_en, wd_en} <= 3'b111;
    for (k = 0; k < 300 && irq !== 1'b1; k++) step(1);
    `CHK({irq, wake, cpu_rst_n}, 3'b110)
    step(1);
    `CHK(wake, 1'b0)
    irq_ack();
    step(1);
    `CHK(irq, 1'b0)
    for (k = 0; k < 300 && wake !== 1'b1; k++) step(1);
    `CHK(wake, 1'b1)
    @(posedge mclk_i);
    {standby, wd_en} <= 2'b00;
    irq_ack();
    step(300);
    `CHK({irq, wake, cpu_rst_n}, 3'b001)
    @(posedge mclk_i);
    {wd_en, kick} <= 2'b11;
    step(300);
    `CHK(irq, 1'b0)
    done("watchdog wake");
    @(posedge mclk_i);
    {kick, rst_en, wake_en} <= 3'b010;
    period <= {14'h0000, rnd[1:0]};
    for (k = 0; k < 300 && irq !== 1'b1; k++) step(1);
    `CHK({irq, wake, cpu_rst_n}, 3'b101)
    for (k = 0; k < 300 && cpu_rst_n !== 1'b0; k++) step(1);
    `CHK(cpu_rst_n, 1'b0)
    @(posedge mclk_i);
    {wd_en, ext_sel, rst_en} <= 3'b000;
    period <= 16'h0000;
    irq_ack();
    step(150);
    `CHK({irq, cpu_rst_n}, 2'b01)
    @(posedge mclk_i);
    wd_en <= 1'b1;
    for (k = 0; k < 8000 && irq !== 1'b1; k++) step(1);
    `CHK(irq, 1'b1)
    done("watchdog reset");
    rnd = lfsr(rnd);
    hard_reset(rnd[2:0], rnd[5:3], rnd[8:6]);
    done("mid-run hard reset");
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
